// ===== shared/sfsb_pkg.sv
// Package: register map, field layout and bus codes of the fault bank
package sfsb_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] SFSB_OFS_PIN = 8'h00;
    localparam logic [7:0] SFSB_OFS_FCTL = 8'h04;
    localparam logic [7:0] SFSB_OFS_FINV = 8'h08;
    localparam logic [7:0] SFSB_OFS_MLAT = 8'h0C;
    localparam logic [7:0] SFSB_OFS_MRT = 8'h10;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SFSB_PIN_LSB = 8;
    localparam int SFSB_RAN_BIT = 1;
    localparam int SFSB_PASS_BIT = 0;
    localparam int SFSB_CLR_BIT = 6;
    localparam int SFSB_CNT_LSB = 2;
    localparam int SFSB_LIM_LSB = 0;
    // ----------------------------------------
    // Reset values and limit codes
    // ----------------------------------------
    localparam logic [1:0] SFSB_LIM_RST = 2'h0;
    localparam logic [1:0] SFSB_INV_RST = 2'h0;
    localparam logic [3:0] SFSB_MAX_C0 = 4'h1;
    localparam logic [3:0] SFSB_MAX_C1 = 4'h2;
    localparam logic [3:0] SFSB_MAX_C2 = 4'h6;
    localparam logic [3:0] SFSB_MAX_C3 = 4'hC;
    // ----------------------------------------
    // AXI response codes
    // ----------------------------------------
    localparam logic [1:0] SFSB_RESP_OK = 2'h0;
    localparam logic [1:0] SFSB_RESP_ERR = 2'h2;
    // Stuck-pin flags, msb first as they sit in bits 13..8
    typedef struct packed {
        logic safe_out_stuck_low;
        logic safe_out_stuck_high;
        logic pg_two_stuck_low;
        logic pg_two_stuck_high;
        logic pg_one_stuck_low;
        logic pg_one_stuck_high;
    } sfsb_pin_t;
    // Monitor conditions, msb first as they sit in bits 14..0
    typedef struct packed {
        logic sw_two_overcurrent_flag;
        logic sw_one_overcurrent_flag;
        logic thermal_shutdown_flag;
        logic [5:0] undervoltage;
        logic [5:0] overvoltage;
    } sfsb_mon_t;
endpackage

// ===== verilog/sfsb_bank.sv
// Safety fault status bank with AXI4-Lite register slave
`timescale 1ns/100ps
// Function
// - Self-test bit 13 flags safe-state pin stuck low.
// - Self-test bit 12 flags safe-state pin stuck high.
// - Bits 11 and 10 flag power-good two stuck low and high.
// - Bits 9 and 8 flag power-good one stuck low and high.
// - Bit 1 reads 1 once the logic self-test has run.
// - Bit 0 reads 1 only when the logic self-test passed.
// - Writing 1 to control bit 6 clears counter, then bit self-clears.
// - Counter value shows as 4-bit unsigned in control bits 5..2.
// - Limit code 00,01,10,11 selects maximum 1,2,6,12.
// - New limit applies only when it equals the inverted shadow.
// - Shadow bit 6 holds the clear companion, written by software.
// - Monitor bits 14 and 13 latch switcher two and one overcurrent.
// - Monitor bit 12 latches thermal shutdown.
// - Monitor bits 11..6 latch undervoltage of switchers and rails.
// - Monitor bits 5..0 latch overvoltage of switchers and rails.
// - All fields return to reset state on power-on reset.
// - A separate real-time view shows present monitor conditions.
module sfsb_bank
    import sfsb_pkg::*;
#(
    parameter int CNT_W = 4,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Fault detector events
    input wire sfsb_pin_t i_pin_fault,
    input wire logic i_lt_done,
    input wire logic i_lt_pass,
    input wire logic i_fault_inc,
    input wire sfsb_mon_t i_mon_cond,
    // Counter state to the supervisor
    output logic [CNT_W-1:0] o_fault_count,
    output logic [1:0] o_fault_limit,
    output logic o_count_at_limit,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (CNT_W != 4) begin : g_bad_cnt
        $error("CNT_W must be 4 to fit the counter field");
    end
    if (ADDR_W < 8) begin : g_bad_addr
        $error("ADDR_W must be at least 8");
    end

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic [3:0] lim_max(input logic [1:0] code);
        logic [3:0] m;
        m = SFSB_MAX_C0;
        unique case (code)
            2'h0: m = SFSB_MAX_C0;
            2'h1: m = SFSB_MAX_C1;
            2'h2: m = SFSB_MAX_C2;
            2'h3: m = SFSB_MAX_C3;
        endcase
        return m;
    endfunction

    // Word select: 0..4 mapped, 7 unmapped
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [2:0] s;
        s = 3'h7;
        if ((a >> 8) == '0) begin
            if (a[7:0] == SFSB_OFS_PIN) s = 3'h0;
            if (a[7:0] == SFSB_OFS_FCTL) s = 3'h1;
            if (a[7:0] == SFSB_OFS_FINV) s = 3'h2;
            if (a[7:0] == SFSB_OFS_MLAT) s = 3'h3;
            if (a[7:0] == SFSB_OFS_MRT) s = 3'h4;
        end
        return s;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [5:0] pin_reg;
    logic lt_ran_reg;
    logic lt_pass_reg;
    logic clr_reg;
    logic [1:0] lim_reg;
    logic inv_clr_reg;
    logic [1:0] inv_lim_reg;
    logic [1:0] applied_reg;
    logic [CNT_W-1:0] count_reg;
    logic at_lim_reg;
    logic [14:0] mlat_reg;
    logic [14:0] mrt_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic aw_full_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic w_full_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire aw_take = i_awvalid && awready_reg;
    wire w_take = i_wvalid && wready_reg;
    wire do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
    wire b_done = bvalid_reg && i_bready;
    wire ar_take = i_arvalid && arready_reg;
    wire r_done = rvalid_reg && i_rready;
    wire [2:0] wsel = reg_sel(awaddr_reg);
    wire [2:0] rsel = reg_sel(i_araddr);
    wire [15:0] wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wire [15:0] wbits = wdata_reg[15:0] & wmask;
    wire wr_fctl = do_wr && wsel == 3'h1;
    wire wr_finv = do_wr && wsel == 3'h2;
    wire wr_mlat = do_wr && wsel == 3'h3;
    wire aw_full_next = (aw_full_reg || aw_take) && !do_wr;
    wire w_full_next = (w_full_reg || w_take) && !do_wr;
    wire bvalid_next = do_wr || (bvalid_reg && !i_bready);
    wire rvalid_next = ar_take || (rvalid_reg && !i_rready);

    // ----------------------------------------
    // Register views
    // ----------------------------------------
    wire [15:0] pin_word = {2'h0, pin_reg, 6'h0, lt_ran_reg, lt_pass_reg};
    wire [15:0] fctl_word = {9'h0, clr_reg, count_reg, lim_reg};
    wire [15:0] finv_word = {9'h0, inv_clr_reg, 4'h0, inv_lim_reg};
    wire [15:0] rd_word =
        rsel == 3'h0 ? pin_word :
        rsel == 3'h1 ? fctl_word :
        rsel == 3'h2 ? finv_word :
        rsel == 3'h3 ? {1'b0, mlat_reg} :
        rsel == 3'h4 ? {1'b0, mrt_reg} : 16'h0000;

    // ----------------------------------------
    // Fault counter logic
    // ----------------------------------------
    // shadow compare
    wire lim_match = lim_reg == ~inv_lim_reg;
    wire [1:0] applied_next = lim_match ? lim_reg : applied_reg;
    wire [3:0] cur_max = lim_max(applied_reg);
    wire [3:0] next_max = lim_max(applied_next);
    wire cnt_room = count_reg < cur_max;
    // Clear wins over a same-cycle increment
    wire [CNT_W-1:0] count_next =
        clr_reg ? '0 :
        (i_fault_inc && cnt_room) ? count_reg + 1'b1 : count_reg;
    wire at_lim_next = count_next >= next_max;
    wire [14:0] mon_now = i_mon_cond;
    // Set wins over a write-one clear
    wire [14:0] mlat_next =
        (mlat_reg & ~(wr_mlat ? wbits[14:0] : 15'h0000)) | mon_now;

    // ----------------------------------------
    // Status and control registers
    // ----------------------------------------
    // power-on reset of every field
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_reg <= 6'h00;
            lt_ran_reg <= 1'b0;
            lt_pass_reg <= 1'b0;
            clr_reg <= 1'b0;
            lim_reg <= SFSB_LIM_RST;
            inv_clr_reg <= 1'b0;
            inv_lim_reg <= SFSB_INV_RST;
            applied_reg <= SFSB_LIM_RST;
            count_reg <= '0;
            at_lim_reg <= 1'b0;
            mlat_reg <= 15'h0000;
            mrt_reg <= 15'h0000;
        end else begin
            pin_reg <= pin_reg | i_pin_fault;
            if (i_lt_done) begin
                lt_ran_reg <= 1'b1;
                lt_pass_reg <= i_lt_pass;
            end
            clr_reg <= wr_fctl && wbits[SFSB_CLR_BIT];
            if (wr_fctl && wstrb_reg[0]) begin
                lim_reg <= wbits[SFSB_LIM_LSB+:2];
            end
            if (wr_finv && wstrb_reg[0]) begin
                inv_clr_reg <= wbits[SFSB_CLR_BIT];
                inv_lim_reg <= wbits[SFSB_LIM_LSB+:2];
            end
            applied_reg <= applied_next;
            count_reg <= count_next;
            at_lim_reg <= at_lim_next;
            mlat_reg <= mlat_next;
            mrt_reg <= mon_now;
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            awaddr_reg <= '0;
            aw_full_reg <= 1'b0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= SFSB_RESP_OK;
        end else begin
            if (aw_take) begin
                awaddr_reg <= i_awaddr;
            end
            if (w_take) begin
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
            end
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            awready_reg <= !aw_full_next && !bvalid_next;
            wready_reg <= !w_full_next && !bvalid_next;
            bvalid_reg <= bvalid_next;
            if (do_wr) begin
                bresp_reg <= wsel == 3'h7 ? SFSB_RESP_ERR : SFSB_RESP_OK;
            end
        end
    end

    // Read side stalls ar while a data beat waits
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= SFSB_RESP_OK;
            rdata_reg <= 32'h00000000;
        end else begin
            arready_reg <= !rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= {16'h0000, rd_word};
                rresp_reg <= rsel == 3'h7 ? SFSB_RESP_ERR : SFSB_RESP_OK;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_fault_count = count_reg;
    assign o_fault_limit = applied_reg;
    assign o_count_at_limit = at_lim_reg;
    assign o_awready = awready_reg;
    assign o_wready = wready_reg;
    assign o_bresp = bresp_reg;
    assign o_bvalid = bvalid_reg;
    assign o_arready = arready_reg;
    assign o_rdata = rdata_reg;
    assign o_rresp = rresp_reg;
    assign o_rvalid = rvalid_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_pin_flag_sticky: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (|i_pin_fault) |=> ((pin_reg & $past(i_pin_fault))
            == $past(i_pin_fault)) && ($past(pin_reg) & ~pin_reg) == 6'h00)
        else $error("stuck pin flag lost or not set");

    chk_test_result: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        i_lt_done |=> lt_ran_reg && lt_pass_reg == $past(i_lt_pass))
        else $error("self-test result not recorded");

    chk_pass_needs_ran: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        lt_pass_reg |-> lt_ran_reg)
        else $error("pass flag without ran flag");

    chk_clear_pulse: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (wr_fctl && wbits[SFSB_CLR_BIT]) |=> clr_reg ##1
            (!clr_reg && count_reg == '0))
        else $error("counter clear did not act or self-clear");

    chk_count_step: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_fault_inc && !clr_reg && cnt_room) |=>
            count_reg == $past(count_reg) + 1'b1)
        else $error("counter did not advance");

    chk_count_cap: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (!cnt_room && !clr_reg) |=> $stable(count_reg))
        else $error("counter passed its limit");

    chk_limit_apply: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        lim_match |=> applied_reg == $past(lim_reg))
        else $error("matching limit not applied");

    chk_limit_hold: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !lim_match |=> $stable(applied_reg))
        else $error("limit changed without shadow match");

    chk_mon_latch: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (|mon_now) |=> (mlat_reg & $past(mon_now)) == $past(mon_now))
        else $error("monitor event not latched");

    chk_mon_keep: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        !wr_mlat |=> ($past(mlat_reg) & ~mlat_reg) == 15'h0000)
        else $error("latched flag dropped without clear");

    chk_rt_view: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        1'b1 |=> mrt_reg == $past(mon_now))
        else $error("real-time view lags");

    chk_write_resp: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        do_wr |=> bvalid_reg && !awready_reg && !wready_reg)
        else $error("write response missing");

    chk_read_resp: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        ar_take |=> rvalid_reg && !arready_reg)
        else $error("read response missing");

    chk_limit_flag: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        at_lim_reg == (count_reg >= lim_max(applied_reg)))
        else $error("at-limit flag disagrees with count");

    chk_count_bound: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_b)
        count_reg <= SFSB_MAX_C3)
        else $error("counter beyond largest limit");

endmodule

// ===== test/sfsb_testbench.sv
// Self-checking testbench for the safety fault status bank
`timescale 1ns/100ps
module testbench;
    import sfsb_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    sfsb_pin_t i_pin_fault = '0;
    logic i_lt_done = 1'b0;
    logic i_lt_pass = 1'b0;
    logic i_fault_inc = 1'b0;
    sfsb_mon_t i_mon_cond = '0;
    logic [3:0] o_fault_count;
    logic [1:0] o_fault_limit;
    logic o_count_at_limit;
    logic [7:0] i_awaddr = 8'h00;
    logic i_awvalid = 1'b0;
    logic o_awready;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'h0;
    logic i_wvalid = 1'b0;
    logic o_wready;
    logic [1:0] o_bresp;
    logic o_bvalid;
    logic i_bready = 1'b0;
    logic [7:0] i_araddr = 8'h00;
    logic i_arvalid = 1'b0;
    logic o_arready;
    logic [31:0] o_rdata;
    logic [1:0] o_rresp;
    logic o_rvalid;
    logic i_rready = 1'b0;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    logic [3:0] wr_strb = 4'hF;
    logic [3:0] mx [4] = '{SFSB_MAX_C0, SFSB_MAX_C1, SFSB_MAX_C2, SFSB_MAX_C3};

    sfsb_bank u_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_pin_fault(i_pin_fault), .i_lt_done(i_lt_done),
        .i_lt_pass(i_lt_pass), .i_fault_inc(i_fault_inc),
        .i_mon_cond(i_mon_cond), .o_fault_count(o_fault_count),
        .o_fault_limit(o_fault_limit), .o_count_at_limit(o_count_at_limit),
        .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
        .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_rvalid(o_rvalid), .i_rready(i_rready));

    always #2.5 i_core_clk = ~i_core_clk;

    // Runs well under 20000 cycles; anything longer is a hang
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("errors %0d of %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge i_core_clk);
        i_awaddr <= a;
        i_awvalid <= 1'b1;
        i_wdata <= d;
        i_wstrb <= wr_strb;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (!aw_done && o_awready === 1'b1) begin
                i_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (!w_done && o_wready === 1'b1) begin
                i_wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end while (!(aw_done && w_done));
        do @(posedge i_core_clk); while (o_bvalid !== 1'b1);
        resp = o_bresp;
        i_bready <= 1'b0;
    endtask

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check("bresp", 32'(r), 32'(SFSB_RESP_OK));
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] resp);
        @(posedge i_core_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(posedge i_core_clk); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        do @(posedge i_core_clk); while (o_rvalid !== 1'b1);
        d = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string name);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(name, d, exp);
        check("rresp", 32'(r), 32'(SFSB_RESP_OK));
    endtask

    task automatic pulse_inc(input int n);
        repeat (n) begin
            @(posedge i_core_clk);
            i_fault_inc <= 1'b1;
            @(posedge i_core_clk);
            i_fault_inc <= 1'b0;
        end
        repeat (2) @(posedge i_core_clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset_state();
        logic [31:0] d;
        logic [1:0] r;
        for (int k = 0; k < 5; k++) begin
            rd_chk(8'(4 * k), 32'h0, "reset value");
        end
        check("limit after reset", 32'(o_fault_limit), 32'h0);
        check("count after reset", 32'(o_fault_count), 32'h0);
        // Unmapped places answer with an error and no data
        axi_read(8'h14, d, r);
        check("unmapped rdata", d, 32'h0);
        check("unmapped rresp", 32'(r), 32'(SFSB_RESP_ERR));
        axi_write(8'h20, 32'hFFFF, r);
        check("unmapped bresp", 32'(r), 32'(SFSB_RESP_ERR));
    endtask

    task automatic test_pins_and_selftest();
        logic [31:0] acc;
        acc = 32'h0;
        for (int i = 0; i < 6; i++) begin
            @(posedge i_core_clk);
            i_pin_fault <= sfsb_pin_t'(6'(1 << i));
            @(posedge i_core_clk);
            i_pin_fault <= '0;
            acc = acc | (32'h1 << (SFSB_PIN_LSB + i));
            rd_chk(SFSB_OFS_PIN, acc, "stuck flags");
        end
        for (int p = 0; p < 2; p++) begin
            @(posedge i_core_clk);
            i_lt_done <= 1'b1;
            i_lt_pass <= p[0];
            @(posedge i_core_clk);
            i_lt_done <= 1'b0;
            i_lt_pass <= 1'b0;
            rd_chk(SFSB_OFS_PIN, acc | 32'h2 | 32'(p), "self-test");
        end
    endtask

    task automatic test_counter_limits();
        logic [1:0] inv;
        for (int c = 0; c < 4; c++) begin
            inv = ~2'(c);
            wr_ok(SFSB_OFS_FINV, 32'h40 | 32'(inv));
            rd_chk(SFSB_OFS_FINV, 32'h40 | 32'(inv), "shadow");
            wr_ok(SFSB_OFS_FCTL, 32'h40 | 32'(c));
            repeat (2) @(posedge i_core_clk);
            check("cleared count", 32'(o_fault_count), 32'h0);
            check("below limit", 32'(o_count_at_limit), 32'h0);
            pulse_inc(14);
            check("limit code", 32'(o_fault_limit), 32'(c));
            check("saturated", 32'(o_fault_count), 32'(mx[c]));
            check("at limit", 32'(o_count_at_limit), 32'h1);
            rd_chk(SFSB_OFS_FCTL, 32'({mx[c], 2'(c)}), "ctrl");
        end
        // Shadow left at 00: code 01 is not its inverse and must not apply
        wr_ok(SFSB_OFS_FCTL, 32'h1);
        repeat (2) @(posedge i_core_clk);
        check("held limit", 32'(o_fault_limit), 32'h3);
        check("count kept", 32'(o_fault_count), 32'(mx[3]));
        rd_chk(SFSB_OFS_FCTL, 32'({mx[3], 2'h1}), "ctrl kept");
        // Upper byte only: limit and clear bits are masked off
        wr_strb = 4'h2;
        wr_ok(SFSB_OFS_FCTL, 32'h43);
        wr_strb = 4'hF;
        rd_chk(SFSB_OFS_FCTL, 32'({mx[3], 2'h1}), "masked write");
    endtask

    task automatic test_monitor();
        logic [31:0] b;
        for (int i = 0; i < 15; i++) begin
            b = 32'h1 << i;
            @(posedge i_core_clk);
            i_mon_cond <= sfsb_mon_t'(15'(b));
            repeat (2) @(posedge i_core_clk);
            rd_chk(SFSB_OFS_MRT, b, "realtime");
            @(posedge i_core_clk);
            i_mon_cond <= '0;
            repeat (2) @(posedge i_core_clk);
            rd_chk(SFSB_OFS_MRT, 32'h0, "realtime gone");
            rd_chk(SFSB_OFS_MLAT, b, "latched");
            wr_ok(SFSB_OFS_MLAT, b);
            rd_chk(SFSB_OFS_MLAT, 32'h0, "latched clear");
        end
        // Event still present while software clears: flag must stay
        @(posedge i_core_clk);
        i_mon_cond <= sfsb_mon_t'(15'h0001);
        repeat (2) @(posedge i_core_clk);
        wr_ok(SFSB_OFS_MLAT, 32'h1);
        rd_chk(SFSB_OFS_MLAT, 32'h1, "set over clear");
        @(posedge i_core_clk);
        i_mon_cond <= '0;
    endtask

    task automatic test_mid_reset();
        @(posedge i_core_clk);
        i_mon_cond <= sfsb_mon_t'(15'h7FFF);
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1'b0;
        i_mon_cond <= '0;
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            rd_chk(8'(4 * k), 32'h0, "value after reset");
        end
        check("count after reset", 32'(o_fault_count), 32'h0);
        check("limit after reset", 32'(o_fault_limit), 32'h0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        test_reset_state();
        test_pins_and_selftest();
        test_counter_limits();
        test_monitor();
        test_mid_reset();
        give_verdict();
    end
endmodule
